// ==== ifs_sender_top.sv ====
// Operation
// R1 - all sections carry burst number, count capped; here only parity section headers carry it, datagram bytes pass unchanged
// R2 - section index counts from zero
// R3 - parity table chosen by index mapping
// R4 - payload is g columns, rows one to T
// R5 - column limit scaled to 255, else 255
// R6 - section count field equals burst total
// R7 - length is columns times rows plus 13
// R8 - earlier burst length from delayed index
// R9 - forward delayed datagram burst in order
// R10 - datagram sections keep increasing address order
// R11 - parity sections join the time-slice burst
// R12 - each section kind keeps own order
// R13 - parity sections go before datagram sections
// R14 - real-time fields set after order fixed
// R15 - shift source column into mapped data table
// R16 - padding columns shifted like data columns
// R17 - trigger parity generation every encoding period
// R18 - parity shares the datagram output stream
// R19 - header field layout and CRC trailer
// R20 - burst counter wraps below 256 on period
// R21 - reserved bits all ones, current flag one
// R22 - last-section flag only on final section
// R23 - CRC covers whole section
`timescale 1ns/1ns
`default_nettype none
module ifs_sender_top
  import ifs_pkg::*;
(
  input wire logic i_mclk, // clock 100 MHz
  input wire logic i_srst, // sync reset, high
  input wire logic i_hsel, // AHB select
  input wire logic [31:0] i_haddr, // AHB address
  input wire logic [1:0] i_htrans, // AHB transfer type
  input wire logic i_hwrite, // AHB write
  input wire logic [2:0] i_hsize, // AHB size, word only
  input wire logic [31:0] i_hwdata, // AHB write data
  input wire logic i_hready, // AHB bus ready
  output logic [31:0] o_hrdata, // AHB read data
  output logic o_hreadyout, // AHB slave ready
  output logic o_hresp, // AHB response
  input wire logic i_burst_valid, // new datagram burst
  input wire logic [17:0] i_burst_size, // its size
  output logic o_burst_ready, // burst accepted
  output logic o_shift_valid, // shift one source column
  output logic [7:0] o_shift_burst, // burst number
  output logic [7:0] o_shift_col, // source column index
  input wire logic [7:0] i_adt_table, // mapped data table
  output logic [7:0] o_shift_table, // target data table
  input wire logic i_shift_ready, // shift done
  output logic o_gen_valid, // compute parity table
  output logic [7:0] o_gen_table, // table to compute
  input wire logic i_gen_done, // computation done
  output logic [7:0] o_map_burst, // burst number to map
  output logic [7:0] o_map_sec, // section index to map
  input wire logic [7:0] i_map_table, // mapped parity table
  input wire logic [15:0] i_map_col, // mapped start column
  output logic [7:0] o_par_table, // parity read table
  output logic [15:0] o_par_col, // parity read column
  output logic [15:0] o_par_row, // parity read row, 1-based
  input wire logic [7:0] i_par_data, // parity byte, same cycle
  output logic [7:0] o_dg_burst, // delayed burst index
  input wire logic i_dg_valid, // datagram byte valid
  input wire logic [7:0] i_dg_data, // datagram byte
  input wire logic i_dg_last, // last byte of burst
  output logic o_dg_ready, // datagram byte taken
  output logic o_tx_valid, // output byte valid
  output logic [7:0] o_tx_data, // output byte
  output logic o_tx_par, // byte of a parity section
  output logic o_tx_sof, // first byte of parity section
  output logic o_tx_eof, // last byte of section or burst
  input wire logic i_tx_ready // downstream ready
);
  function automatic logic [7:0] f_nz(input logic [7:0] v);
    f_nz = (v == 8'h00) ? 8'h01 : v;
  endfunction

  // assumes the subtrahend stays below twice the modulus
  function automatic logic [7:0] f_mod_sub(input logic [7:0] a, input logic [9:0] b,
                                           input logic [7:0] m);
    logic [9:0] s;
    s = 10'({2'b00, a} + {1'b0, m, 1'b0} - b);
    f_mod_sub = 8'(s % {2'b00, m});
  endfunction

  logic [31:0] ctrl_r, cfg0_r, cfg1_r, cfg2_r, maxcol_r, hrdata_r;
  logic wr_pend_r;
  logic [7:0] waddr_r;
  ifs_state_t state_r;
  logic [7:0] k_r, k_inc, colj_r, sec_r;
  logic [17:0] sz_r [SIZE_DEPTH];
  logic [15:0] bidx_r, row_r, col_r, tx_pos_r;
  logic tx_valid_r, tx_par_r, tx_sof_r, tx_eof_r;
  logic [7:0] tx_data_r;
  logic [7:0] ep, dly, rmax, mcnt, nsec, g, ccols, jmax, kmax, dg_idx, prev_idx;
  logic [7:0] hdr_byte, emit_byte, mc_field;
  logic [15:0] trows, ncols, plen, last_idx;
  logic [11:0] sec_len;
  logic [31:0] crc_val;
  logic [1:0] crc_k;
  logic acc, accept, adv, emit_now, in_pay, in_crc, gen_due, dg_empty, frame_bnd, sec_end;
  ifs_state_t after_emit, after_shift;

  assign ep = f_nz(cfg0_r[CFG0_EP_LSB +: 8]);
  assign dly = cfg0_r[CFG0_D_LSB +: 8];
  assign rmax = cfg0_r[CFG0_R_LSB +: 8];
  assign mcnt = f_nz(cfg0_r[CFG0_M_LSB +: 8]);
  assign nsec = (cfg1_r[CFG1_NSEC_LSB +: 8] > rmax) ? rmax : cfg1_r[CFG1_NSEC_LSB +: 8]; // R1
  assign g = f_nz(cfg1_r[CFG1_G_LSB +: 8]); // R4
  assign ccols = cfg1_r[CFG1_C_LSB +: 8];
  assign jmax = f_nz(cfg1_r[CFG1_JMAX_LSB +: 8]);
  assign trows = cfg2_r[CFG2_T_LSB +: 16];
  assign ncols = (cfg2_r[CFG2_N_LSB +: 16] == 16'h0000) ? 16'h0001 : cfg2_r[CFG2_N_LSB +: 16];
  assign kmax = (KMAX_LIMIT / ep) * ep; // R20
  assign k_inc = ({1'b0, k_r} + 9'h001 >= {1'b0, kmax}) ? 8'h00 : 8'(k_r + 8'h01); // R20
  assign plen = 16'(g * trows);
  assign sec_len = 12'(plen + LEN_OVERHEAD); // R7
  assign last_idx = 16'(HDR_LEN + plen + CRC_LEN - 16'h0001);
  assign dg_idx = f_mod_sub(k_r, {2'b00, dly}, kmax); // R9
  assign prev_idx = f_mod_sub(k_r, 10'({2'b00, dly} + {2'b00, sec_r % jmax} + 10'h001), kmax); // R8
  assign dg_empty = (sz_r[dg_idx] == 18'h00000);
  assign gen_due = ((({1'b0, k_r} + 9'h001) % {1'b0, ep}) == 9'h000); // R17
  assign mc_field = ctrl_r[CTRL_UNK] ? MAXCOL_UNKNOWN :
    8'(({24'h000000, COL_SCALE} * ({16'h0000, maxcol_r[15:0]} + 32'h0000_0001))
       / {16'h0000, ncols}); // R5
  assign frame_bnd = (sec_r == 8'(nsec - 8'h01)); // R22

  // register bus, zero wait states
  assign acc = i_hsel & i_htrans[1] & i_hready;
  assign o_hreadyout = 1'b1;
  assign o_hresp = HRESP_OKAY;
  assign o_hrdata = hrdata_r;

  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      wr_pend_r <= 1'b0;
      waddr_r <= 8'h00;
      hrdata_r <= 32'h0000_0000;
    end
    else
    begin
      wr_pend_r <= acc & i_hwrite;
      if (acc)
        waddr_r <= i_haddr[7:0];
      if (acc & ~i_hwrite)
      begin
        case (i_haddr[7:0])
          ADDR_CTRL: hrdata_r <= ctrl_r;
          ADDR_CFG0: hrdata_r <= cfg0_r;
          ADDR_CFG1: hrdata_r <= cfg1_r;
          ADDR_CFG2: hrdata_r <= cfg2_r;
          ADDR_MAXCOL: hrdata_r <= maxcol_r;
          ADDR_STATUS: hrdata_r <= {21'h000000, state_r, k_r};
          default: hrdata_r <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      ctrl_r <= CTRL_RST;
      cfg0_r <= CFG0_RST;
      cfg1_r <= CFG1_RST;
      cfg2_r <= CFG2_RST;
      maxcol_r <= MAXCOL_RST;
    end
    else if (wr_pend_r)
    begin
      case (waddr_r)
        ADDR_CTRL: ctrl_r <= i_hwdata;
        ADDR_CFG0: cfg0_r <= i_hwdata;
        ADDR_CFG1: cfg1_r <= i_hwdata;
        ADDR_CFG2: cfg2_r <= i_hwdata;
        ADDR_MAXCOL: maxcol_r <= i_hwdata;
        default: ;
      endcase
    end
  end

  // burst counter and stored burst sizes
  assign o_burst_ready = (state_r == ST_IDLE) & ctrl_r[CTRL_EN];
  assign accept = o_burst_ready & i_burst_valid;

  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
      k_r <= 8'h00;
    else if (accept)
      k_r <= k_inc; // R20
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      for (int i = 0; i < SIZE_DEPTH; i++)
        sz_r[i] <= 18'h00000;
    end
    else if (accept)
      sz_r[k_inc] <= i_burst_size;
  end

  // sequencing: shift columns, maybe generate parity, parity sections, then datagrams
  assign after_emit = dg_empty ? ST_IDLE : ST_DGRAM;
  assign after_shift = gen_due ? ST_GEN : ((nsec != 8'h00) ? ST_EMIT : after_emit);
  assign adv = ~tx_valid_r | i_tx_ready;
  assign sec_end = adv & (bidx_r == last_idx);

  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      state_r <= ST_IDLE;
      colj_r <= 8'h00;
    end
    else
    begin
      unique case (state_r)
        ST_IDLE:
        begin
          colj_r <= 8'h00;
          if (accept)
            state_r <= ST_SHIFT;
        end
        ST_SHIFT:
        begin
          if (ccols == 8'h00)
            state_r <= after_shift;
          else if (i_shift_ready)
          begin
            colj_r <= 8'(colj_r + 8'h01); // R15
            if (colj_r == 8'(ccols - 8'h01))
              state_r <= after_shift;
          end
        end
        ST_GEN:
          if (i_gen_done)
            state_r <= (nsec != 8'h00) ? ST_EMIT : after_emit;
        ST_EMIT:
          if (sec_end && frame_bnd)
            state_r <= after_emit; // R13
        ST_DGRAM:
          if (adv && i_dg_valid && i_dg_last)
            state_r <= ST_IDLE;
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // padding and data columns are not told apart here
  assign o_shift_valid = (state_r == ST_SHIFT) & (ccols != 8'h00); // R15 R16
  assign o_shift_burst = k_r;
  assign o_shift_col = colj_r;
  assign o_shift_table = i_adt_table; // R15
  assign o_gen_valid = (state_r == ST_GEN);
  assign o_gen_table = (k_r / ep) % mcnt; // R17

  // parity section byte counters
  assign in_pay = (bidx_r >= HDR_LEN) && (bidx_r < 16'(HDR_LEN + plen));
  assign in_crc = (bidx_r >= 16'(HDR_LEN + plen));
  assign crc_k = 2'(bidx_r - HDR_LEN - plen);

  always_ff @(posedge i_mclk)
  begin
    if (i_srst || state_r != ST_EMIT)
    begin
      bidx_r <= 16'h0000;
      row_r <= 16'h0000;
      col_r <= 16'h0000;
      sec_r <= 8'h00;
    end
    else if (sec_end)
    begin
      bidx_r <= 16'h0000;
      row_r <= 16'h0000;
      col_r <= 16'h0000;
      sec_r <= 8'(sec_r + 8'h01); // R2
    end
    else if (adv)
    begin
      bidx_r <= 16'(bidx_r + 16'h0001);
      if (in_pay && row_r == 16'(trows - 16'h0001))
      begin
        row_r <= 16'h0000;
        col_r <= 16'(col_r + 16'h0001); // R4
      end
      else if (in_pay)
        row_r <= 16'(row_r + 16'h0001);
    end
  end

  assign o_map_burst = k_r; // R1
  assign o_map_sec = sec_r;
  assign o_par_table = i_map_table; // R3
  assign o_par_col = 16'(i_map_col + col_r); // R4
  assign o_par_row = 16'(row_r + 16'h0001); // R4
  assign o_dg_burst = dg_idx;

  ifs_hdr_byte u_hdr (
    .i_idx(bidx_r[3:0]),
    .i_len(sec_len),
    .i_burst(k_r),
    .i_sec(sec_r),
    .i_maxcol(mc_field),
    .i_cnt(nsec),
    .i_delta_t(ctrl_r[CTRL_DT_LSB +: 12]),
    .i_mpe_bnd(dg_empty),
    .i_frame_bnd(frame_bnd),
    .i_prev(sz_r[prev_idx]),
    .o_byte(hdr_byte)
  ); // R14

  ifs_crc32 u_crc (
    .i_mclk(i_mclk),
    .i_srst(i_srst),
    .i_clr((state_r != ST_EMIT) | sec_end),
    .i_en((state_r == ST_EMIT) & adv & ~in_crc),
    .i_byte(emit_byte),
    .o_crc(crc_val)
  ); // R23

  always_comb
  begin
    if (bidx_r < HDR_LEN)
      emit_byte = hdr_byte;
    else if (in_pay)
      emit_byte = i_par_data;
    else
      emit_byte = crc_val[(5'd24 - {crc_k, 3'b000}) +: 8]; // R19 R23
  end

  // one output stream for both kinds of section
  assign emit_now = (state_r == ST_EMIT) | ((state_r == ST_DGRAM) & i_dg_valid);
  assign o_dg_ready = (state_r == ST_DGRAM) & adv; // R10 R12

  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      tx_valid_r <= 1'b0;
      tx_data_r <= 8'h00;
      tx_par_r <= 1'b0;
      tx_sof_r <= 1'b0;
      tx_eof_r <= 1'b0;
      tx_pos_r <= 16'h0000;
    end
    else if (adv)
    begin
      tx_valid_r <= emit_now; // R18 R11
      tx_data_r <= (state_r == ST_EMIT) ? emit_byte : i_dg_data; // R9
      tx_par_r <= (state_r == ST_EMIT);
      tx_sof_r <= (state_r == ST_EMIT) && (bidx_r == 16'h0000);
      tx_eof_r <= (state_r == ST_EMIT) ? (bidx_r == last_idx) : i_dg_last;
      tx_pos_r <= bidx_r;
    end
  end

  assign o_tx_valid = tx_valid_r;
  assign o_tx_data = tx_data_r;
  assign o_tx_par = tx_par_r;
  assign o_tx_sof = tx_sof_r;
  assign o_tx_eof = tx_eof_r;

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_srst);

  sequence s_shift_step;
    o_shift_valid && i_shift_ready && colj_r != 8'(ccols - 8'h01);
  endsequence
  sequence s_emit_leave;
    state_r == ST_EMIT ##1 state_r == ST_DGRAM;
  endsequence

  burst_num_a: assert property (o_tx_valid && o_tx_par && tx_pos_r == {12'h000, HB_BURST}
    |-> o_tx_data == k_r) else $error("burst number byte wrong"); // R1
  sec_index_a: assert property (state_r == ST_EMIT |-> sec_r < nsec)
    else $error("section index out of range"); // R2
  len_field_a: assert property (o_tx_valid && o_tx_par && tx_pos_r == {12'h000, HB_LEN_LO}
    |-> o_tx_data == 8'(plen + LEN_OVERHEAD)) else $error("section length wrong"); // R7
  rsv_bits_a: assert property (o_tx_valid && o_tx_par && tx_pos_r == {12'h000, HB_CUR}
    |-> o_tx_data == 8'hFF) else $error("reserved bits wrong"); // R21
  kmax_range_a: assert property ($changed(k_r) |-> k_r < kmax)
    else $error("burst counter beyond modulus"); // R20
  gen_due_a: assert property ($rose(o_gen_valid) |-> $past(state_r) == ST_SHIFT && gen_due
    && o_gen_table == (k_r / ep) % mcnt) else $error("parity generation off period"); // R17
  shift_step_a: assert property (s_shift_step |=> o_shift_valid
    && colj_r == 8'($past(colj_r) + 8'h01)) else $error("shift column skipped"); // R15
  crc_clear_a: assert property (state_r == ST_EMIT && sec_end |=> crc_val == CRC_INIT)
    else $error("crc not restarted per section"); // R23
  emit_leave_a: assert property (s_emit_leave |-> $past(bidx_r) == last_idx
    && $past(sec_r) == 8'(nsec - 8'h01)) else $error("datagrams before parity end"); // R13
  dg_pass_a: assert property (o_dg_ready && i_dg_valid |=> o_tx_valid && !o_tx_par
    && o_tx_data == $past(i_dg_data)) else $error("datagram byte lost"); // R9
endmodule
`default_nettype wire

// ==== ifs_pkg.sv ====
`default_nettype none
package ifs_pkg;
  // register byte offsets, one 32-bit word each
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CFG0 = 8'h04;
  localparam logic [7:0] ADDR_CFG1 = 8'h08;
  localparam logic [7:0] ADDR_CFG2 = 8'h0C;
  localparam logic [7:0] ADDR_MAXCOL = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  // field positions
  localparam int CTRL_EN = 0;
  localparam int CTRL_UNK = 1;
  localparam int CTRL_DT_LSB = 16;
  localparam int CFG0_EP_LSB = 24;
  localparam int CFG0_D_LSB = 16;
  localparam int CFG0_R_LSB = 8;
  localparam int CFG0_M_LSB = 0;
  localparam int CFG1_NSEC_LSB = 24;
  localparam int CFG1_G_LSB = 16;
  localparam int CFG1_C_LSB = 8;
  localparam int CFG1_JMAX_LSB = 0;
  localparam int CFG2_T_LSB = 16;
  localparam int CFG2_N_LSB = 0;
  // reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] CFG0_RST = 32'h0101_0401;
  localparam logic [31:0] CFG1_RST = 32'h0401_0101;
  localparam logic [31:0] CFG2_RST = 32'h0010_0004;
  localparam logic [31:0] MAXCOL_RST = 32'h0000_0000;
  localparam logic HRESP_OKAY = 1'b0;
  // section layout
  localparam int SIZE_DEPTH = 256;
  localparam logic [15:0] HDR_LEN = 16'h000C;
  localparam logic [15:0] CRC_LEN = 16'h0004;
  localparam logic [15:0] LEN_OVERHEAD = 16'h000D;
  localparam logic [7:0] TABLE_ID = 8'h79;
  localparam logic [7:0] KMAX_LIMIT = 8'hFF;
  localparam logic [7:0] COL_SCALE = 8'hFF;
  localparam logic [7:0] MAXCOL_UNKNOWN = 8'hFF;
  localparam logic SYNTAX_IND = 1'b1;
  localparam logic PRIV_IND = 1'b0;
  localparam logic CUR_NEXT = 1'b1;
  localparam logic [1:0] RSV2 = 2'h3;
  localparam logic [6:0] RSV7 = 7'h7F;
  localparam logic [31:0] CRC_POLY = 32'h04C1_1DB7;
  localparam logic [31:0] CRC_INIT = 32'hFFFF_FFFF;
  // header byte positions
  localparam logic [3:0] HB_TID = 4'h0;
  localparam logic [3:0] HB_LEN_HI = 4'h1;
  localparam logic [3:0] HB_LEN_LO = 4'h2;
  localparam logic [3:0] HB_BURST = 4'h3;
  localparam logic [3:0] HB_CUR = 4'h4;
  localparam logic [3:0] HB_SEC = 4'h5;
  localparam logic [3:0] HB_MAXCOL = 4'h6;
  localparam logic [3:0] HB_CNT = 4'h7;
  localparam logic [3:0] HB_RT0 = 4'h8;
  localparam logic [3:0] HB_RT1 = 4'h9;
  localparam logic [3:0] HB_RT2 = 4'hA;
  localparam logic [3:0] HB_RT3 = 4'hB;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SHIFT = 3'b001,
    ST_GEN = 3'b010,
    ST_EMIT = 3'b011,
    ST_DGRAM = 3'b100
  } ifs_state_t;
endpackage
`default_nettype wire

// ==== ifs_crc32.sv ====
`timescale 1ns/1ns
`default_nettype none
module ifs_crc32
  import ifs_pkg::*;
(
  input wire logic i_mclk, // clock
  input wire logic i_srst, // sync reset
  input wire logic i_clr, // restart at init value
  input wire logic i_en, // absorb i_byte
  input wire logic [7:0] i_byte, // byte, msb first
  output logic [31:0] o_crc // running value
);
  function automatic logic [31:0] f_step(input logic [31:0] c, input logic [7:0] b);
    logic [31:0] v;
    v = c;
    for (int i = 7; i >= 0; i--)
    begin
      v = {v[30:0], 1'b0} ^ ((v[31] ^ b[i]) ? CRC_POLY : 32'h0000_0000);
    end
    f_step = v;
  endfunction

  logic [31:0] base;
  assign base = i_clr ? CRC_INIT : o_crc;

  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
      o_crc <= CRC_INIT;
    else if (i_en)
      o_crc <= f_step(base, i_byte);
    else if (i_clr)
      o_crc <= CRC_INIT;
  end
endmodule
`default_nettype wire

// ==== ifs_hdr_byte.sv ====
`timescale 1ns/1ns
`default_nettype none
module ifs_hdr_byte
  import ifs_pkg::*;
(
  input wire logic [3:0] i_idx, // header byte position
  input wire logic [11:0] i_len, // section length field
  input wire logic [7:0] i_burst, // burst number
  input wire logic [7:0] i_sec, // section index
  input wire logic [7:0] i_maxcol, // parity column limit
  input wire logic [7:0] i_cnt, // sections in this burst
  input wire logic [11:0] i_delta_t, // time to next burst
  input wire logic i_mpe_bnd, // no datagram section follows
  input wire logic i_frame_bnd, // last parity section
  input wire logic [17:0] i_prev, // earlier burst length
  output logic [7:0] o_byte // header byte
);
  logic [31:0] rt;
  assign rt = {i_delta_t, i_mpe_bnd, i_frame_bnd, i_prev};

  always_comb
  begin
    unique case (i_idx)
      HB_TID: o_byte = TABLE_ID; // R19
      HB_LEN_HI: o_byte = {SYNTAX_IND, PRIV_IND, RSV2, i_len[11:8]}; // R19
      HB_LEN_LO: o_byte = i_len[7:0];
      HB_BURST: o_byte = i_burst; // R1
      HB_CUR: o_byte = {RSV7, CUR_NEXT}; // R21
      HB_SEC: o_byte = i_sec; // R2
      HB_MAXCOL: o_byte = i_maxcol;
      HB_CNT: o_byte = i_cnt; // R6
      HB_RT0: o_byte = rt[31:24];
      HB_RT1: o_byte = rt[23:16];
      HB_RT2: o_byte = rt[15:8];
      HB_RT3: o_byte = rt[7:0];
      default: o_byte = 8'h00;
    endcase
  end
endmodule
`default_nettype wire

// ==== ifs_far_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module ifs_far_model
  import ifs_pkg::*;
(
  input wire logic i_mclk, // clock
  input wire logic i_srst, // sync reset
  input wire logic i_slow, // answer late
  input wire logic i_rewind, // restart datagram store
  input wire logic i_shift_valid, // shift request
  input wire logic [7:0] i_shift_col, // source column
  output logic [7:0] o_adt_table, // mapped data table
  output logic o_shift_ready, // shift done
  input wire logic i_gen_valid, // parity request
  output logic o_gen_done, // parity done
  input wire logic [7:0] i_map_burst, // burst to map
  input wire logic [7:0] i_map_sec, // section to map
  output logic [7:0] o_map_table, // parity table
  output logic [15:0] o_map_col, // start column
  input wire logic [7:0] i_par_table, // read table
  input wire logic [15:0] i_par_col, // read column
  input wire logic [15:0] i_par_row, // read row
  output logic [7:0] o_par_data, // parity byte
  input wire logic i_dg_ready, // byte taken
  output logic o_dg_valid, // byte offered
  output logic [7:0] o_dg_data, // datagram byte
  output logic o_dg_last // last byte
);
  logic [1:0] wait_r;
  logic [1:0] cnt_r;
  logic late;
  assign late = i_slow & (wait_r != 2'h2);
  always_ff @(posedge i_mclk)
  begin
    if (i_srst | ~(i_shift_valid | i_gen_valid) | ~late)
      wait_r <= 2'h0;
    else
      wait_r <= wait_r + 2'h1;
  end
  assign o_shift_ready = i_shift_valid & ~late;
  assign o_gen_done = i_gen_valid & ~late;
  assign o_adt_table = i_shift_col ^ 8'h05;
  assign o_map_table = i_map_burst ^ i_map_sec;
  assign o_map_col = {7'h00, i_map_sec, 1'b0};
  assign o_par_data = i_par_table ^ i_par_col[7:0] ^ i_par_row[7:0];
  // three bytes per burst; a drained store shows a fixed byte 0x5C, not the last byte
  always_ff @(posedge i_mclk)
  begin
    if (i_srst | i_rewind)
      cnt_r <= 2'h0;
    else if (o_dg_valid & i_dg_ready)
      cnt_r <= cnt_r + 2'h1;
  end
  assign o_dg_valid = cnt_r != 2'h3;
  assign o_dg_data = o_dg_valid ? 8'hA0 + {6'h00, cnt_r} : 8'h5F - {6'h00, cnt_r};
  assign o_dg_last = cnt_r == 2'h2;
endmodule
`default_nettype wire

// ==== ifs_sender_top_bench.sv ====
`timescale 1ns/1ns
`default_nettype none
module ifs_sender_top_bench;
  import ifs_pkg::*;
  localparam int EP = 2, D = 1, RR = 2, MM = 2, GG = 2, CC = 3, JM = 2, TT = 4, KMAX = 254;
  logic i_mclk = 1'b0;
  logic i_srst = 1'b1;
  logic i_hsel = 1'b0, i_hwrite = 1'b0, i_hready, i_burst_valid = 1'b0, i_tx_ready = 1'b1;
  logic i_shift_ready, i_gen_done, i_dg_valid, i_dg_last;
  logic [31:0] i_haddr = 32'h0, i_hwdata = 32'h0, o_hrdata;
  logic [1:0] i_htrans = 2'h0;
  logic [2:0] i_hsize = 3'h2;
  logic [17:0] i_burst_size = 18'h0;
  logic o_hreadyout, o_hresp, o_burst_ready, o_shift_valid, o_gen_valid, o_dg_ready;
  logic o_tx_valid, o_tx_par, o_tx_sof, o_tx_eof;
  logic [7:0] o_shift_burst, o_shift_col, i_adt_table, o_shift_table, o_gen_table, o_map_burst;
  logic [7:0] o_map_sec, i_map_table, o_par_table, i_par_data, o_dg_burst, i_dg_data, o_tx_data;
  logic [15:0] i_map_col, o_par_col, o_par_row;
  logic slow = 1'b0, rewind = 1'b0;
  logic [7:0] k = 8'h0, gtab;
  logic [10:0] got[$], expq[$];
  logic [17:0] sz[256];
  int fail_count = 0, comparisons = 0, cyc = 0, scnt, gcnt;
  assign i_hready = o_hreadyout;
  ifs_sender_top ifs_sender_top_inst (.*);
  ifs_far_model ifs_far_model_inst (
    .i_mclk(i_mclk), .i_srst(i_srst), .i_slow(slow), .i_rewind(rewind),
    .i_shift_valid(o_shift_valid), .i_shift_col(o_shift_col), .o_adt_table(i_adt_table),
    .o_shift_ready(i_shift_ready), .i_gen_valid(o_gen_valid), .o_gen_done(i_gen_done),
    .i_map_burst(o_map_burst), .i_map_sec(o_map_sec), .o_map_table(i_map_table),
    .o_map_col(i_map_col), .i_par_table(o_par_table), .i_par_col(o_par_col),
    .i_par_row(o_par_row), .o_par_data(i_par_data), .i_dg_ready(o_dg_ready),
    .o_dg_valid(i_dg_valid), .o_dg_data(i_dg_data), .o_dg_last(i_dg_last));
  initial
  begin
    forever #5 i_mclk = ~i_mclk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // downstream stalls one cycle in four so held bytes get exercised
  always @(posedge i_mclk)
  begin
    cyc <= cyc + 1;
    i_tx_ready <= (cyc % 4) != 3;
    if (cyc == 20000)
    begin
      fail_count++;
      print_verdict();
    end
  end
  always @(posedge i_mclk)
  begin
    if (o_tx_valid === 1'b1 && i_tx_ready)
      got.push_back({o_tx_par, o_tx_sof, o_tx_eof, o_tx_data});
    if (o_shift_valid === 1'b1 && i_shift_ready)
    begin
      check(o_shift_col, scnt);
      check(o_shift_table, o_shift_col ^ 8'h05);
      check(o_shift_burst, k);
      scnt++;
    end
    if (o_dg_ready === 1'b1 && i_dg_valid)
      check(o_dg_burst, 8'((k - D + KMAX) % KMAX));
    if (o_gen_valid === 1'b1 && i_gen_done)
    begin
      gtab = o_gen_table;
      gcnt++;
    end
  end
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    i_hsel <= 1'b1;
    i_haddr <= {24'h0, a};
    i_htrans <= 2'h2;
    i_hwrite <= w;
    do @(posedge i_mclk); while (o_hreadyout !== 1'b1);
    i_htrans <= 2'h0;
    i_hwdata <= wd;
    do @(posedge i_mclk); while (o_hreadyout !== 1'b1);
    rd = o_hrdata;
    check(o_hresp, HRESP_OKAY);
  endtask
  function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 7; i >= 0; i--)
      r = {r[30:0], 1'b0} ^ ((r[31] ^ d[i]) ? CRC_POLY : 32'h0);
    return r;
  endfunction
  task automatic run_burst(input logic [17:0] size, input logic unk, input logic sl);
    logic [31:0] rd, rt, crc;
    logic [7:0] hb[$];
    logic [7:0] p;
    int dl;
    ahb(1'b1, ADDR_CTRL, {4'h0, 12'h123, 14'h0, unk, 1'b1}, rd);
    k = 8'((k + 1) % KMAX);
    sz[k] = size;
    dl = sz[8'((k - D + KMAX) % KMAX)] != 0 ? 3 : 0;
    for (int j = 0; j < RR; j++)
    begin
      hb = {8'h79, 8'hB0, 8'h15, k, 8'hFF, 8'(j), unk ? 8'hFF : 8'h7F, 8'h02};
      p = 8'((k - D - j % JM - 1 + 2 * KMAX) % KMAX);
      rt = {12'h123, dl == 0, j == RR - 1, sz[p]};
      for (int b = 3; b >= 0; b--)
        hb.push_back(rt[8*b +: 8]);
      for (int c = 0; c < GG; c++)
        for (int r = 1; r <= TT; r++)
          hb.push_back(8'(k ^ j ^ (2 * j + c) ^ r));
      crc = CRC_INIT;
      foreach (hb[i])
        crc = crc_step(crc, hb[i]);
      for (int b = 3; b >= 0; b--)
        hb.push_back(crc[8*b +: 8]);
      foreach (hb[i])
        expq.push_back({1'b1, i == 0, i == 23, hb[i]});
    end
    for (int i = 0; i < dl; i++)
      expq.push_back({2'b00, i == dl - 1, 8'hA0 + 8'(i)});
    scnt = 0;
    gcnt = 0;
    slow <= sl;
    rewind <= 1'b1;
    i_burst_valid <= 1'b1;
    i_burst_size <= size;
    // hold the offer until the block says it is idle and enabled
    do @(posedge i_mclk); while (o_burst_ready !== 1'b1);
    i_burst_valid <= 1'b0;
    rewind <= 1'b0;
    while (got.size() < expq.size())
      @(posedge i_mclk);
    repeat (4) @(posedge i_mclk);
    check(got.size(), expq.size());
    foreach (expq[i])
      check(got[i], expq[i]);
    check(scnt, CC);
    check(gcnt, (k + 1) % EP == 0);
    if (gcnt == 1)
      check(gtab, (k / EP) % MM);
    got.delete();
    expq.delete();
  endtask
  initial
  begin
    logic [31:0] rd;
    logic [7:0] adr[6] = '{ADDR_CTRL, ADDR_CFG0, ADDR_CFG1, ADDR_CFG2, ADDR_MAXCOL, 8'h40};
    logic [31:0] rv[6] = '{CTRL_RST, CFG0_RST, CFG1_RST, CFG2_RST, MAXCOL_RST, 32'h0};
    foreach (sz[i])
      sz[i] = 18'h0;
    repeat (16) @(posedge i_mclk);
    i_srst <= 1'b0;
    @(posedge i_mclk);
    foreach (adr[i])
    begin
      ahb(1'b0, adr[i], 32'h0, rd);
      check(rd, rv[i]);
    end
    ahb(1'b1, ADDR_CFG0, 32'h0201_0202, rd);
    ahb(1'b1, ADDR_CFG1, 32'h0302_0302, rd);
    ahb(1'b1, ADDR_CFG2, 32'h0004_0004, rd);
    ahb(1'b1, ADDR_MAXCOL, 32'h0000_0001, rd);
    ahb(1'b0, ADDR_CFG1, 32'h0, rd);
    check(rd, 32'h0302_0302);
    run_burst(18'h2_0003, 1'b0, 1'b0);
    run_burst(18'h0_0002, 1'b0, 1'b1);
    run_burst(18'h0_0000, 1'b1, 1'b0);
    ahb(1'b0, ADDR_STATUS, 32'h0, rd);
    check(rd, {21'h000000, ST_IDLE, k});
    print_verdict();
  end
endmodule
`default_nettype wire
